//--- core/smc_axil.sv
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/1ps
module smc_axil #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output smc_pkg::smc_wr_t wr,
  output logic wr_go,
  input wire logic wr_ok,
  output logic [9:0] rd_idx,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  // Both halves held and no response pending: one write strobe.
  assign wr_go = !awready && !wready && !bvalid;
  assign rd_idx = araddr[AW-1:2];

  // Address and data are taken in either order; ready drops while held.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      wr <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr.idx <= awaddr[AW-1:2];
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wr.data <= wdata;
        wr.strb <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0;
      rresp <= rd_ok ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : smc_axil

//--- core/smc_pkg.sv
// Package of constants and types for the supply monitor control block.
package smc_pkg;
  // ********************************************
  // Register indices (byte address is index * 4)
  // ********************************************
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_OSC = 10'h1e0;
  localparam logic [9:0] IDX_LVDCFG = 10'h1e3;
  localparam logic [9:0] IDX_VCMP = 10'h1e4;
  localparam logic [9:0] IDX_TRIM = 10'h1eb;
  localparam logic [9:0] IDX_CPUF = 10'h0f7;
  localparam logic [9:0] IDX_ISTAT = 10'h0f8;
  localparam logic [9:0] IDX_IMASK = 10'h0f9;
  localparam logic [9:0] IDX_BASE_TOP = 10'h0ff;
  // ********************************************
  // Field positions, masks and reset values
  // ********************************************
  localparam int EXT_FLAG_BIT = 4;
  localparam int LVD_BIT = 1;
  localparam int POR_BIT = 0;
  localparam int EV_LVD_BIT = 0;
  localparam logic [1:0] TRIP_HIGH = 2'h2;
  localparam logic [7:0] OSC_MASK = 8'h3f;
  localparam logic [7:0] LVDCFG_MASK = 8'h37;
  localparam logic [7:0] TRIM_MASK = 8'hc0;
  localparam logic [7:0] CPUF_MASK = 8'h10;
  localparam logic [7:0] EV_MASK = 8'h01;
  localparam logic [7:0] RST_OSC = 8'h00;
  localparam logic [7:0] RST_LVDCFG = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_CPUF = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************************
  // Carrier types
  // ********************************************
  typedef struct packed {
    logic [9:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } smc_wr_t;
  typedef struct packed {
    logic [2:0] cpu_speed;
    logic [1:0] sleep_timer;
    logic no_buzz;
    logic [1:0] trip_level;
    logic [2:0] threshold;
    logic [1:0] sleep_duty;
  } smc_ctrl_t;
endpackage : smc_pkg

//--- core/smc_supply_ctrl.sv
// Supply monitor control: reset trip level, low-voltage detect and status.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module smc_supply_ctrl #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic lvd_comp_raw,
  input wire logic por_comp_raw,
  output smc_pkg::smc_ctrl_t ctrl,
  output logic high_trip,
  output logic [7:0] trip_onehot,
  output logic reset_req,
  output logic irq
);
  // ********************************************
  // Bus front end
  // ********************************************
  smc_pkg::smc_wr_t wr;
  logic wr_go;
  logic wr_ok;
  logic [9:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_ok;

  smc_axil #(.AW(AW)) u_bus (
    .clk(clk),
    .reset_n(reset_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_go(wr_go),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ********************************************
  // Comparator inputs
  // ********************************************
  logic [1:0] comp_s;
  logic lvd_s;
  logic por_s;
  logic lvd_q;
  logic lvd_rise;

  smc_sync #(.W(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({lvd_comp_raw, por_comp_raw}),
    .dout(comp_s)
  );

  // Comparators are analog and asynchronous, so they are filtered first.
  assign lvd_s = comp_s[1];
  assign por_s = comp_s[0];
  assign lvd_rise = lvd_s && !lvd_q;

  // ********************************************
  // Registers
  // ********************************************
  logic [7:0] osc;
  logic [7:0] lvdcfg;
  logic [7:0] trim;
  logic [7:0] cpuf;
  logic [7:0] istat;
  logic [7:0] imask;
  logic [7:0] vcmp;
  logic ext_flag;

  assign ext_flag = cpuf[smc_pkg::EXT_FLAG_BIT];
  assign vcmp = {6'h00, lvd_s, por_s};

  // Address decode; the upper bank is fenced by the extended-space flag.
  logic rd_hi;
  logic wr_hi;
  logic rd_known;
  logic wr_known;
  assign rd_hi = rd_idx > smc_pkg::IDX_BASE_TOP;
  assign wr_hi = wr.idx > smc_pkg::IDX_BASE_TOP;
  assign rd_known = (rd_idx == smc_pkg::IDX_OSC) || (rd_idx == smc_pkg::IDX_LVDCFG)
    || (rd_idx == smc_pkg::IDX_VCMP) || (rd_idx == smc_pkg::IDX_TRIM)
    || (rd_idx == smc_pkg::IDX_CPUF) || (rd_idx == smc_pkg::IDX_ISTAT)
    || (rd_idx == smc_pkg::IDX_IMASK);
  assign wr_known = (wr.idx == smc_pkg::IDX_OSC) || (wr.idx == smc_pkg::IDX_LVDCFG)
    || (wr.idx == smc_pkg::IDX_VCMP) || (wr.idx == smc_pkg::IDX_TRIM)
    || (wr.idx == smc_pkg::IDX_CPUF) || (wr.idx == smc_pkg::IDX_ISTAT)
    || (wr.idx == smc_pkg::IDX_IMASK);
  assign rd_ok = rd_known && !(rd_hi && !ext_flag);
  assign wr_ok = wr_known && !(wr_hi && !ext_flag);

  // Read data selection; reserved bits read as zero.
  logic [7:0] rd_byte;
  assign rd_byte = (rd_idx == smc_pkg::IDX_OSC) ? osc
    : (rd_idx == smc_pkg::IDX_LVDCFG) ? lvdcfg
    : (rd_idx == smc_pkg::IDX_VCMP) ? vcmp
    : (rd_idx == smc_pkg::IDX_TRIM) ? trim
    : (rd_idx == smc_pkg::IDX_CPUF) ? cpuf
    : (rd_idx == smc_pkg::IDX_ISTAT) ? istat
    : (rd_idx == smc_pkg::IDX_IMASK) ? imask : 8'h00;
  assign rd_data = {24'h000000, rd_byte};

  // Write strobes; only the low byte lane carries register data.
  logic wr_live;
  logic we_osc;
  logic we_lvd;
  logic we_trim;
  logic we_cpuf;
  logic we_mask;
  logic we_stat;
  logic [7:0] wbyte;
  assign wr_live = wr_go && wr_ok && wr.strb[0];
  assign wbyte = wr.data[7:0];
  assign we_osc = wr_live && (wr.idx == smc_pkg::IDX_OSC);
  assign we_lvd = wr_live && (wr.idx == smc_pkg::IDX_LVDCFG);
  assign we_trim = wr_live && (wr.idx == smc_pkg::IDX_TRIM);
  assign we_cpuf = wr_live && (wr.idx == smc_pkg::IDX_CPUF);
  assign we_mask = wr_live && (wr.idx == smc_pkg::IDX_IMASK);
  assign we_stat = wr_live && (wr.idx == smc_pkg::IDX_ISTAT);

  // Software-written configuration. Speed is not policed against the trip
  // level: firmware owns the ordering of level, threshold and speed.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc <= smc_pkg::RST_OSC;
      lvdcfg <= smc_pkg::RST_LVDCFG;
      trim <= smc_pkg::RST_TRIM;
      cpuf <= smc_pkg::RST_CPUF;
      imask <= smc_pkg::RST_IRQ;
    end else begin
      if (we_osc) osc <= wbyte & smc_pkg::OSC_MASK;
      if (we_lvd) lvdcfg <= wbyte & smc_pkg::LVDCFG_MASK;
      if (we_trim) trim <= wbyte & smc_pkg::TRIM_MASK;
      if (we_cpuf) cpuf <= wbyte & smc_pkg::CPUF_MASK;
      if (we_mask) imask <= wbyte & smc_pkg::EV_MASK;
    end
  end

  // ********************************************
  // Events and interrupt
  // ********************************************
  logic [7:0] ev;
  logic [7:0] next_istat;
  logic [7:0] w1c;
  assign ev = {7'h00, lvd_rise};
  assign w1c = we_stat ? wbyte : 8'h00;
  // A new event beats a clear in the same cycle, so none is lost.
  assign next_istat = (ev | (istat & ~w1c)) & smc_pkg::EV_MASK;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvd_q <= 1'b0;
      istat <= smc_pkg::RST_IRQ;
      irq <= 1'b0;
    end else begin
      lvd_q <= lvd_s;
      istat <= next_istat;
      irq <= |(istat & imask);
    end
  end

  // ********************************************
  // Trip-point control outputs
  // ********************************************
  assign ctrl.cpu_speed = osc[2:0];
  assign ctrl.sleep_timer = osc[4:3];
  assign ctrl.no_buzz = osc[5];
  assign ctrl.trip_level = lvdcfg[5:4];
  assign ctrl.threshold = lvdcfg[2:0];
  assign ctrl.sleep_duty = trim[7:6];

  // Reset request follows the comparator once the high level is chosen;
  // on a slow ramp this can fire repeatedly until the supply clears it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_trip <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      high_trip <= ctrl.trip_level == smc_pkg::TRIP_HIGH;
      reset_req <= high_trip && por_s;
    end
  end

  // One-hot select for the eight detector trip points.
  for (genvar i = 0; i < 8; i++) begin : g_thr
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        trip_onehot[i] <= 1'b0;
      end else begin
        trip_onehot[i] <= ctrl.threshold == 3'(i);
      end
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_high_write;
    we_lvd && (wbyte[5:4] == smc_pkg::TRIP_HIGH);
  endsequence

  sequence s_hi_read_fenced;
    arvalid && arready && rd_hi && !ext_flag;
  endsequence

  // One-cycle-back checks stay quiet on the edge that leaves reset, where
  // the flops still hold their reset values although the disable has lifted.
  sequence s_out_of_reset;
    $past(reset_n);
  endsequence

  // A detector config write whose trip code is anything but the high one.
  sequence s_low_write;
    we_lvd && (wbyte[5:4] != smc_pkg::TRIP_HIGH);
  endsequence

  // A one written to the pending bit with no new event in the same cycle.
  sequence s_event_clear;
    we_stat && wbyte[smc_pkg::EV_LVD_BIT] && !lvd_rise;
  endsequence

  chk_ext_read_fence: assert property (s_hi_read_fenced |=>
    rvalid && rresp == smc_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("upper bank read answered without extended flag");

  chk_ext_write_fence: assert property (wr_go && wr_hi && !ext_flag |=>
    bresp == smc_pkg::RESP_SLVERR && osc == $past(osc)
    && lvdcfg == $past(lvdcfg) && trim == $past(trim))
    else $error("upper bank write took effect without extended flag");

  chk_high_trip_sel: assert property (s_high_write ##1 1'b1 |=> high_trip)
    else $error("high trip level not selected after write of 10b");

  chk_high_trip_drop: assert property (s_low_write ##1 1'b1 |=> !high_trip)
    else $error("high trip level kept after write of another code");

  chk_thr_onehot: assert property (s_out_of_reset |-> trip_onehot ==
    (8'h01 << $past(ctrl.threshold)))
    else $error("trip point select does not match threshold code");

  chk_status_mirror: assert property (arvalid && arready && rd_idx == smc_pkg::IDX_VCMP
    && ext_flag |=> rdata[smc_pkg::LVD_BIT] == $past(lvd_s))
    else $error("status bit 1 does not follow detector");

  chk_reset_request: assert property (high_trip && por_s |=> reset_req)
    else $error("reset not requested under high trip level");

  chk_reset_quiet: assert property (!high_trip |=> !reset_req)
    else $error("reset requested while the high trip level is off");

  chk_event_sticky: assert property (lvd_rise |=> istat[smc_pkg::EV_LVD_BIT] ##1
    (irq == imask[smc_pkg::EV_LVD_BIT]))
    else $error("detector event not latched or interrupt gating wrong");

  chk_event_clear: assert property (s_event_clear |=> !istat[smc_pkg::EV_LVD_BIT])
    else $error("pending detector event survived a write of one");

  chk_irq_masked: assert property (istat == 8'h00 |=> !irq)
    else $error("interrupt raised with no pending event");
endmodule : smc_supply_ctrl

//--- core/smc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module smc_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Stage one feeds only stage two, so metastability never reaches a gate.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 == s3) ? s3 : dout;
    end
  end
endmodule : smc_sync

//--- dv/smc_supply_ctrl_bench.sv
// Self-checking bench for the supply monitor control block.
`timescale 1ns/1ps
module smc_supply_ctrl_bench;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] rd;
    logic [1:0] resp;
  } smc_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic lvd_comp_raw = 1'b0, por_comp_raw = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, high_trip, reset_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] trip_onehot;
  smc_pkg::smc_ctrl_t ctrl;
  smc_row_t rows [8];
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  smc_supply_ctrl #(.AW(12)) uut (
    .clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lvd_comp_raw(lvd_comp_raw), .por_comp_raw(por_comp_raw), .ctrl(ctrl),
    .high_trip(high_trip), .trip_onehot(trip_onehot), .reset_req(reset_req), .irq(irq)
  );

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Comparison, bus and closing tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Address and data go out together and each is dropped at its own acceptance edge.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic w(input logic [9:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, 4'hf, r);
    chk($sformatf("bresp_%h", idx), r, smc_pkg::RESP_OKAY);
  endtask : w

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    chk($sformatf("rdata_%h", idx), rdata, exp);
    chk($sformatf("rresp_%h", idx), rresp, er);
    rready <= 1'b0;
  endtask : rdchk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [1:0] rs;
    rows[0] = '{smc_pkg::IDX_CPUF, smc_pkg::CPUF_MASK, smc_pkg::RESP_OKAY};
    rows[1] = '{smc_pkg::IDX_OSC, smc_pkg::OSC_MASK, smc_pkg::RESP_OKAY};
    rows[2] = '{smc_pkg::IDX_LVDCFG, smc_pkg::LVDCFG_MASK, smc_pkg::RESP_OKAY};
    rows[3] = '{smc_pkg::IDX_TRIM, smc_pkg::TRIM_MASK, smc_pkg::RESP_OKAY};
    rows[4] = '{smc_pkg::IDX_IMASK, smc_pkg::EV_MASK, smc_pkg::RESP_OKAY};
    rows[5] = '{smc_pkg::IDX_VCMP, 8'h00, smc_pkg::RESP_OKAY};
    rows[6] = '{smc_pkg::IDX_ISTAT, 8'h00, smc_pkg::RESP_OKAY};
    rows[7] = '{10'h1f0, 8'h00, smc_pkg::RESP_SLVERR};
    repeat (3) @(posedge clk);
    chk("awready_rst", awready, 1'b1);
    reset_n <= 1'b1;
    // Extended registers refuse access until the flag is set.
    rdchk(smc_pkg::IDX_OSC, 32'h0, smc_pkg::RESP_SLVERR);
    wr(smc_pkg::IDX_LVDCFG, 8'h20, 4'hf, rs);
    chk("bresp_noflag", rs, smc_pkg::RESP_SLVERR);
    w(smc_pkg::IDX_CPUF, 8'h10);
    rdchk(smc_pkg::IDX_LVDCFG, 32'h0, smc_pkg::RESP_OKAY);
    for (int i = 1; i < 7; i++) rdchk(rows[i].idx, 32'h0, smc_pkg::RESP_OKAY);
    // Table of registers: write all ones, read back the writable bits.
    foreach (rows[i]) begin
      wr(rows[i].idx, 8'hff, 4'hf, rs);
      chk("row_bresp", rs, rows[i].resp);
      rdchk(rows[i].idx, {24'h0, rows[i].rd}, rows[i].resp);
    end
    w(smc_pkg::IDX_OSC, 8'h2d);
    w(smc_pkg::IDX_IMASK, 8'h00);
    chk("ctrl_osc", {ctrl.no_buzz, ctrl.sleep_timer, ctrl.cpu_speed}, 32'h2d);
    chk("ctrl_cfg", {ctrl.trip_level, ctrl.sleep_duty},
        {smc_pkg::LVDCFG_MASK[5:4], smc_pkg::TRIM_MASK[7:6]});
    // Every detector code gives its own one-hot trip point.
    for (int k = 0; k < 8; k++) begin
      w(smc_pkg::IDX_LVDCFG, 8'(k));
      repeat (2) @(posedge clk);
      chk("trip_onehot", trip_onehot, 32'(8'h01 << k));
      chk("threshold", ctrl.threshold, k[2:0]);
    end
    // Only the 10b trip code selects the high reset point.
    for (int k = 0; k < 4; k++) begin
      w(smc_pkg::IDX_LVDCFG, {2'b00, k[1:0], 4'h6});
      repeat (2) @(posedge clk);
      chk("high_trip", high_trip, k == 2);
    end
    wr(smc_pkg::IDX_LVDCFG, 8'h00, 4'h0, rs);
    chk("bresp_nostrb", rs, smc_pkg::RESP_OKAY);
    rdchk(smc_pkg::IDX_LVDCFG, 32'h36, smc_pkg::RESP_OKAY);
    // Slow ramp: high threshold first, wait for the status to clear, then raise the trip.
    w(smc_pkg::IDX_LVDCFG, 8'h07);
    lvd_comp_raw <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk(smc_pkg::IDX_VCMP, 32'h2, smc_pkg::RESP_OKAY);
    chk("irq_masked", irq, 1'b0);
    rdchk(smc_pkg::IDX_ISTAT, 32'h1, smc_pkg::RESP_OKAY);
    lvd_comp_raw <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(smc_pkg::IDX_VCMP, 32'h0, smc_pkg::RESP_OKAY);
    w(smc_pkg::IDX_ISTAT, 8'h01);
    w(smc_pkg::IDX_LVDCFG, 8'h27);
    por_comp_raw <= 1'b1;
    repeat (8) @(posedge clk);
    chk("reset_req_high", reset_req, 1'b1);
    rdchk(smc_pkg::IDX_VCMP, 32'h1, smc_pkg::RESP_OKAY);
    por_comp_raw <= 1'b0;
    repeat (8) @(posedge clk);
    chk("reset_req_clr", reset_req, 1'b0);
    // Dip handling: the enabled interrupt fires and the handler lowers the trip.
    w(smc_pkg::IDX_IMASK, 8'h01);
    chk("irq_clear", irq, 1'b0);
    lvd_comp_raw <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq_dip", irq, 1'b1);
    w(smc_pkg::IDX_LVDCFG, 8'h07);
    por_comp_raw <= 1'b1;
    lvd_comp_raw <= 1'b0;
    repeat (8) @(posedge clk);
    chk("reset_req_low", reset_req, 1'b0);
    chk("irq_sticky", irq, 1'b1);
    w(smc_pkg::IDX_ISTAT, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_w1c", irq, 1'b0);
    rdchk(smc_pkg::IDX_ISTAT, 32'h0, smc_pkg::RESP_OKAY);
    por_comp_raw <= 1'b0;
    // A reset in mid-run clears the flag, so extended space is shut again.
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq_rst", irq, 1'b0);
    reset_n <= 1'b1;
    rdchk(smc_pkg::IDX_CPUF, 32'h0, smc_pkg::RESP_OKAY);
    rdchk(smc_pkg::IDX_LVDCFG, 32'h0, smc_pkg::RESP_SLVERR);
    tally_and_finish();
  end
endmodule : smc_supply_ctrl_bench
